// ==== logic/uart_rx_errors_tx_end.sv ====
// Purpose: Serial channel: transmit end handling, reception and errors
// Assumes: 8 data bits, 1 stop bit, bit time set by divisor register
// Notes:   Divisor below 2 is treated as 2
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "uart_defines.svh"
//
// Contract
// - Pending word keeps busy, next frame sent
// - Last completion irq with busy reading 0
// - Clearing unit or tx enable resets transmitter
// - Unit enable first, then receive enable
// - Falling edge starts; low at start sample
// - Line sampled on serial clock into shifter
// - Disabled receiver idle, buffer kept, no irq
// - Stop bit: completion irq and buffer load
// - Overrun: no load, routed interrupt
// - Parity/framing error: finish frame, load, route
// - Receive disable mid-frame stops silently
// - Error flag set with its interrupt
// - Reading error status clears all flags
// - Routing bit picks error or completion irq
// - Framing error when stop bit missing
// - Overrun when unread buffer gets new frame
// - Even parity generate and check
// - Odd parity generate and check
// - Zero parity sends 0, no check
// - No parity bit, no check
// - Tx completion irq at stop bit start
// - Buffer-full flag shows write not allowed
module uart_rx_errors_tx_end
  import uart_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       rx_data_line,
  output logic            tx_data_line,
  output logic            tx_complete_irq,
  output logic            rx_complete_irq,
  output logic            rx_error_irq
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] mode_q;
  logic [7:0] div_q;
  logic [7:0] rdata_q;
  logic [2:0] err_q;
  logic       tx_full_q;
  logic       tx_busy_q;
  logic [7:0] tx_buf_q;
  logic [7:0] rx_buf_q;
  logic       unread_q;
  logic       rx_active_q;
  logic       rx_en_prev_q;
  logic       unit_prev_q;
  logic       tx_on;
  logic [7:0] bit_len;
  parity_e    par;

  assign tx_on   = mode_q[`MODE_UNIT] & mode_q[`MODE_TXEN];
  assign bit_len = (div_q < 8'h02) ? 8'h02 : div_q;
  assign par     = parity_e'(mode_q[`MODE_PAR_HI:`MODE_PAR_LO]);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode_q <= `MODE_RST;
      div_q  <= `DIV_RST;
    end else if (wr) begin
      if (addr == `OFS_MODE) mode_q <= wdata;
      if (addr == `OFS_DIV)  div_q  <= wdata;
    end
  end

  // Read data stand one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else if (rd) begin
      case (addr)
        `OFS_MODE:  rdata_q <= mode_q;
        `OFS_ERRST: rdata_q <= {5'h00, err_q};
        `OFS_TXST:  rdata_q <= {6'h00, tx_full_q, tx_busy_q};
        `OFS_RXBUF: rdata_q <= rx_buf_q;
        `OFS_DIV:   rdata_q <= div_q;
        default:    rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign rdata = rdata_q;

  // ordered enabling
  // Arms only on a receive-enable rise after unit enable already stood
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_active_q  <= 1'b0;
      rx_en_prev_q <= 1'b0;
      unit_prev_q  <= 1'b0;
    end else begin
      rx_en_prev_q <= mode_q[`MODE_RXEN];
      unit_prev_q  <= mode_q[`MODE_UNIT];
      if (!mode_q[`MODE_UNIT] || !mode_q[`MODE_RXEN]) begin
        rx_active_q <= 1'b0;
      end else if (!rx_en_prev_q && unit_prev_q) begin
        rx_active_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  frame_e     tx_st_q;
  logic [7:0] tx_cnt_q;
  logic [3:0] tx_bit_q;
  logic [7:0] tx_sh_q;
  logic       tx_par_q;
  logic       tx_tick;
  logic       tx_irq_q;
  logic       tx_line_q;

  assign tx_tick = (tx_cnt_q == 8'h00);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_full_q <= 1'b0;
      tx_buf_q  <= 8'h00;
    end else if (!tx_on) begin
      tx_full_q <= 1'b0;
    end else if (wr && addr == `OFS_TXBUF && !tx_full_q) begin
      tx_buf_q  <= wdata;
      tx_full_q <= 1'b1;
    end else if (tx_st_q == S_IDLE && tx_full_q) begin
      tx_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_st_q   <= S_IDLE;
      tx_cnt_q  <= 8'h00;
      tx_bit_q  <= 4'h0;
      tx_sh_q   <= 8'h00;
      tx_par_q  <= 1'b0;
      tx_busy_q <= 1'b0;
      tx_irq_q  <= 1'b0;
      tx_line_q <= 1'b1;
    end else if (!tx_on) begin
      tx_st_q   <= S_IDLE;
      tx_busy_q <= 1'b0;
      tx_irq_q  <= 1'b0;
      tx_line_q <= 1'b1;
      tx_cnt_q  <= 8'h00;
    end else begin
      tx_irq_q <= 1'b0;
      tx_cnt_q <= tx_tick ? 8'h00 : tx_cnt_q - 8'h01;
      case (tx_st_q)
        S_IDLE: begin
          if (tx_full_q) begin
            tx_sh_q   <= tx_buf_q;
            tx_par_q  <= (par == PAR_EVEN) ? ^tx_buf_q :
                         (par == PAR_ODD) ? ~^tx_buf_q : 1'b0;
            tx_busy_q <= 1'b1;
            tx_line_q <= 1'b0;
            tx_cnt_q  <= bit_len - 8'h01;
            tx_st_q   <= S_START;
          end
        end
        S_START, S_DATA: begin
          if (tx_tick) begin
            tx_cnt_q <= bit_len - 8'h01;
            if (tx_st_q == S_START || tx_bit_q != `DATA_BITS) begin
              tx_line_q <= tx_sh_q[0];
              tx_sh_q   <= {1'b0, tx_sh_q[7:1]};
              tx_bit_q  <= tx_bit_q + 4'h1;
              tx_st_q   <= S_DATA;
            end else if (par != PAR_NONE) begin
              tx_line_q <= tx_par_q;
              tx_st_q   <= S_PAR;
            end else begin
              tx_line_q <= 1'b1;
              tx_irq_q  <= 1'b1;
              tx_busy_q <= tx_full_q | (wr && addr == `OFS_TXBUF);
              tx_st_q   <= S_STOP;
            end
            if (tx_st_q == S_START) tx_bit_q <= 4'h1;
          end
        end
        S_PAR: begin
          if (tx_tick) begin
            // irq as stop bit goes out
            tx_cnt_q  <= bit_len - 8'h01;
            tx_line_q <= 1'b1;
            tx_irq_q  <= 1'b1;
            // busy drops with last irq; a word landing now still counts
            tx_busy_q <= tx_full_q | (wr && addr == `OFS_TXBUF);
            tx_st_q   <= S_STOP;
          end
        end
        S_STOP: begin
          if (tx_full_q) tx_busy_q <= 1'b1;
          if (tx_tick) begin
            tx_bit_q <= 4'h0;
            tx_st_q  <= S_IDLE;
          end
        end
        default: tx_st_q <= S_IDLE;
      endcase
    end
  end
  assign tx_data_line    = tx_line_q;
  assign tx_complete_irq = tx_irq_q;

  // ****************************************************************
  // Receiver
  // ****************************************************************
  frame_e     rx_st_q;
  logic [7:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic       rx_par_q;
  logic       rx_prev_q;
  logic       rx_tick;
  logic       done;
  logic       pe;
  logic       fe;
  logic       overrun_error_flag;
  logic       err;
  logic       err_rd;
  logic       buf_rd;
  logic       rxc_q;
  logic       rxe_q;

  assign rx_tick = (rx_cnt_q == 8'h00);
  assign done    = rx_active_q && rx_st_q == S_STOP && rx_tick;
  assign fe      = !rx_data_line;
  assign pe      = (par == PAR_EVEN) ? (^rx_sh_q ^ rx_par_q) :
                   (par == PAR_ODD) ? ~(^rx_sh_q ^ rx_par_q) : 1'b0;
  assign overrun_error_flag     = unread_q;
  assign err     = pe | fe | overrun_error_flag;
  assign err_rd  = rd && addr == `OFS_ERRST;
  assign buf_rd  = rd && addr == `OFS_RXBUF;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_st_q   <= S_IDLE;
      rx_cnt_q  <= 8'h00;
      rx_bit_q  <= 4'h0;
      rx_sh_q   <= 8'h00;
      rx_par_q  <= 1'b0;
      rx_prev_q <= 1'b1;
    end else if (!rx_active_q) begin
      rx_st_q   <= S_IDLE;
      rx_cnt_q  <= 8'h00;
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= rx_data_line;
      rx_cnt_q  <= rx_tick ? 8'h00 : rx_cnt_q - 8'h01;
      case (rx_st_q)
        S_IDLE: begin
          if (rx_prev_q && !rx_data_line) begin
            rx_cnt_q <= {1'b0, bit_len[7:1]} - 8'h01;
            rx_st_q  <= S_START;
          end
        end
        S_START: begin
          if (rx_tick) begin
            rx_cnt_q <= bit_len - 8'h01;
            rx_bit_q <= 4'h0;
            rx_st_q  <= rx_data_line ? S_IDLE : S_DATA;
          end
        end
        S_DATA: begin
          if (rx_tick) begin
            rx_cnt_q <= bit_len - 8'h01;
            rx_sh_q  <= {rx_data_line, rx_sh_q[7:1]};
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == `DATA_BITS - 4'h1) begin
              rx_st_q <= (par == PAR_NONE) ? S_STOP : S_PAR;
            end
          end
        end
        S_PAR: begin
          if (rx_tick) begin
            rx_cnt_q <= bit_len - 8'h01;
            rx_par_q <= rx_data_line;
            rx_st_q  <= S_STOP;
          end
        end
        S_STOP: begin
          // frame ends here even with errors
          if (rx_tick) rx_st_q <= S_IDLE;
        end
        default: rx_st_q <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_buf_q <= 8'h00;
      unread_q <= 1'b0;
    end else if (done && !overrun_error_flag) begin
      rx_buf_q <= rx_sh_q;
      unread_q <= 1'b1;
    end else if (buf_rd) begin
      unread_q <= 1'b0;
    end
  end

  // flags set beside irq; set beats read clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      err_q <= 3'h0;
    end else if (done && err) begin
      err_q <= {pe, fe, overrun_error_flag};
    end else if (err_rd) begin
      err_q <= 3'h0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rxc_q <= 1'b0;
      rxe_q <= 1'b0;
    end else begin
      rxc_q <= done && (!err || mode_q[`MODE_ROUTE]);
      rxe_q <= done && err && !mode_q[`MODE_ROUTE];
    end
  end
  assign rx_complete_irq = rxc_q;
  assign rx_error_irq    = rxe_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_busy_pend;
    tx_complete_irq && tx_full_q |-> tx_busy_q ##1 tx_busy_q;
  endproperty
  a_busy_pend: assert property (p_busy_pend) else $error("busy fell with word pending");

  property p_last_irq;
    tx_complete_irq && !tx_full_q && !$past(tx_full_q) |-> !tx_busy_q;
  endproperty
  a_last_irq: assert property (p_last_irq) else $error("busy set at last irq");

  property p_tx_off;
    !tx_on |=> !tx_busy_q && !tx_full_q && tx_data_line;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("transmitter not reset");

  property p_arm;
    $rose(rx_active_q) |-> $past(mode_q[`MODE_UNIT], 2) && !$past(mode_q[`MODE_RXEN], 2);
  endproperty
  a_arm: assert property (p_arm) else $error("receiver armed out of order");

  property p_rx_off;
    !rx_active_q |=> rx_st_q == S_IDLE && !rx_complete_irq && !rx_error_irq && $stable(rx_buf_q);
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("disabled receiver active");

  property p_load;
    done && !unread_q |=> rx_buf_q == $past(rx_sh_q) && (rx_complete_irq || rx_error_irq);
  endproperty
  a_load: assert property (p_load) else $error("frame not loaded");

  property p_ovr;
    done && unread_q |=> $stable(rx_buf_q) && err_q[`ERR_OVR];
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun overwrote buffer");

  property p_route;
    rx_error_irq |-> !$past(mode_q[`MODE_ROUTE]) && err_q != 3'h0;
  endproperty
  a_route: assert property (p_route) else $error("error irq misrouted");

  property p_clear;
    err_rd && !done |=> err_q == 3'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("status not cleared by read");

  property p_frame;
    done && !rx_data_line |=> err_q[`ERR_FRM];
  endproperty
  a_frame: assert property (p_frame) else $error("framing error missed");

  c_back2back: cover property (tx_complete_irq && tx_full_q);
  c_overrun:   cover property (done && unread_q);
  c_err_route: cover property (rx_error_irq);
  c_good_rx:   cover property (rx_complete_irq && err_q == 3'h0);
endmodule : uart_rx_errors_tx_end
`default_nettype wire

// ==== inc/uart_defines.svh ====
// Purpose: Offsets, field positions and reset values of the serial channel
// Assumes: Word-wide register port with 3-bit address
// Notes:   Included by bare name
`ifndef UART_DEFINES_SVH
`define UART_DEFINES_SVH
// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_MODE    3'h0
`define OFS_ERRST   3'h1
`define OFS_TXST    3'h2
`define OFS_RXBUF   3'h3
`define OFS_TXBUF   3'h4
`define OFS_DIV     3'h5
// ****************************************************************
// Mode register fields
// ****************************************************************
`define MODE_UNIT   7
`define MODE_TXEN   6
`define MODE_RXEN   5
`define MODE_PAR_HI 4
`define MODE_PAR_LO 3
`define MODE_ROUTE  0
`define MODE_RST    8'h00
// ****************************************************************
// Status fields and reset values
// ****************************************************************
`define ERR_PAR     2
`define ERR_FRM     1
`define ERR_OVR     0
`define TXST_FULL   1
`define TXST_BUSY   0
`define DIV_RST     8'h10
`define DATA_BITS   4'h8
`endif

// ==== inc/uart_pkg.sv ====
// Purpose: Types of the serial channel
// Assumes: Nothing
// Notes:   Parity encoding shared by bus and frame logic
package uart_pkg;
  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_ZERO = 2'h1,
    PAR_ODD  = 2'h2,
    PAR_EVEN = 2'h3
  } parity_e;
  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_START = 5'h02,
    S_DATA  = 5'h04,
    S_PAR   = 5'h08,
    S_STOP  = 5'h10
  } frame_e;
endpackage : uart_pkg

// ==== tb/serial_peer.sv ====
// Purpose: Remote serial peer: sends frames in, decodes frames out
// Assumes: Fixed bit time of BIT_LEN clocks, one stop bit
// Notes:   Line idles high between frames, as a pulled-up link would
`timescale 1ns/10ps
`default_nettype none
module serial_peer
  import uart_pkg::*;
#(
  parameter int BIT_LEN = 16
) (
  input  wire logic       clock,
  input  wire logic       tx_data_line,
  input  wire logic [1:0] par,
  output var  logic       rx_data_line
);
  logic [9:0] q[$];
  logic [9:0] f;
  initial rx_data_line = 1'b1;
  // ****************************************************************
  // Frame sender
  // ****************************************************************
  task automatic send_frame(input logic [7:0] d, input logic pb, input logic stop);
    logic [9:0] bits;
    int         n;
    bits = {pb, d, 1'b0};
    n = (par == PAR_NONE) ? 9 : 10;
    for (int i = 0; i <= n; i++) begin
      @(posedge clock);
      rx_data_line <= (i == n) ? stop : bits[i];
      repeat (BIT_LEN - 1) @(posedge clock);
    end
    @(posedge clock);
    rx_data_line <= 1'b1;
  endtask : send_frame
  // ****************************************************************
  // Frame decoder, mid-bit sampling
  // ****************************************************************
  always begin
    @(negedge tx_data_line);
    repeat (BIT_LEN / 2) @(posedge clock);
    f = '0;
    for (int i = 0; i < ((par == PAR_NONE) ? 9 : 10); i++) begin
      repeat (BIT_LEN) @(posedge clock);
      f[i] = tx_data_line;
    end
    if (par == PAR_NONE) f = {f[8], 1'b0, f[7:0]};
    q.push_back(f);
  end
endmodule : serial_peer
`default_nettype wire

// ==== tb/uart_rx_errors_tx_end_bench.sv ====
// Purpose: Self-checking bench of the serial channel
// Assumes: Divisor left at reset value, 16 clocks a bit
// Notes:   Receive interrupt pulses are counted, not waited for; the transmit completion pulse is waited for
`timescale 1ns/10ps
`default_nettype none
module uart_rx_errors_tx_end_bench
  import uart_pkg::*;
;
  logic       clock = 1'b0;
  logic       rstn = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       rx_data_line;
  logic       tx_data_line;
  logic       tx_complete_irq;
  logic       rx_complete_irq;
  logic       rx_error_irq;
  logic [1:0] par = 2'h0;
  logic [7:0] n_rxc = 8'h00;
  logic [7:0] n_rxe = 8'h00;
  logic [7:0] e_c = 8'h00;
  logic [7:0] e_e = 8'h00;
  logic [9:0] f;
  int         fails = 0;
  int         n_compared = 0;
  always #10 clock = ~clock;
  uart_rx_errors_tx_end i_dut (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .rx_data_line(rx_data_line),
    .tx_data_line(tx_data_line), .tx_complete_irq(tx_complete_irq),
    .rx_complete_irq(rx_complete_irq), .rx_error_irq(rx_error_irq));
  serial_peer i_peer (.clock(clock), .tx_data_line(tx_data_line), .par(par),
    .rx_data_line(rx_data_line));
  // X on a pulse poisons the count, so it cannot pass unseen
  always @(posedge clock) begin
    n_rxc <= n_rxc + {7'h0, rx_complete_irq};
    n_rxe <= n_rxe + {7'h0, rx_error_irq};
  end
  // ****************************************************************
  // Access and compare tasks
  // ****************************************************************
  task automatic end_sim();
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    d = rdata;
  endtask : rd_reg
  task automatic rchk(input logic [2:0] a, input logic [7:0] exp, input string nm);
    logic [7:0] d;
    rd_reg(a, d);
    chk(nm, d, exp);
  endtask : rchk
  task automatic arm(input logic [7:0] m);
    wr_reg(3'h0, 8'h80);
    wr_reg(3'h0, m);
  endtask : arm
  task automatic irq_chk();
    chk("rx_complete_count", n_rxc, e_c);
    chk("rx_error_count", n_rxe, e_e);
  endtask : irq_chk
  task automatic wait_q();
    for (int i = 0; i < 400 && i_peer.q.size() == 0; i++) @(posedge clock);
    f = (i_peer.q.size() > 0) ? i_peer.q.pop_front() : 10'h3ff;
  endtask : wait_q
  task automatic wait_txc();
    for (int i = 0; i < 400; i++) begin
      @(negedge clock);
      if (tx_complete_irq === 1'b1) break;
    end
    chk("tx_irq_seen", {7'h0, tx_complete_irq}, 8'h01);
    chk("tx_line_at_irq", {7'h0, tx_data_line}, 8'h01);
  endtask : wait_txc
  function automatic logic pbit(input logic [1:0] p, input logic [7:0] d);
    return (p == PAR_EVEN) ? ^d : (p == PAR_ODD) ? ~^d : 1'b0;
  endfunction : pbit
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    logic [7:0] d;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    rchk(3'h0, 8'h00, "mode");
    rchk(3'h5, 8'h10, "divisor");
    rchk(3'h1, 8'h00, "err_status");
    rchk(3'h2, 8'h00, "tx_status");
    rchk(3'h6, 8'h00, "unmapped");
    wr_reg(3'h0, 8'ha0);
    i_peer.send_frame(8'h81, 1'b0, 1'b1);
    irq_chk();
    for (int p = 0; p < 4; p++) begin
      par = p[1:0];
      d = 8'h35 + p[7:0];
      arm({3'b111, p[1:0], 3'b000});
      fork
        i_peer.send_frame(d, pbit(par, d), 1'b1);
        wr_reg(3'h4, ~d);
      join
      wait_q();
      chk("tx_data", f[7:0], ~d);
      chk("tx_par_stop", {6'h0, f[9:8]}, {6'h0, 1'b1, pbit(par, ~d)});
      rchk(3'h3, d, "rx_buffer");
      rchk(3'h1, 8'h00, "err_status");
      e_c = e_c + 8'h01;
      irq_chk();
      i_peer.send_frame(d, ~pbit(par, d), 1'b1);
      rchk(3'h3, d, "rx_buffer");
      rchk(3'h1, (p >= 2) ? 8'h04 : 8'h00, "err_status");
      if (p >= 2) e_e = e_e + 8'h01;
      else e_c = e_c + 8'h01;
      irq_chk();
      rchk(3'h1, 8'h00, "err_status");
    end
    par = PAR_EVEN;
    arm(8'hd8);
    wr_reg(3'h4, 8'ha5);
    for (int i = 0; i < 50; i++) begin
      rd_reg(3'h2, d);
      if (d[1] === 1'b0) break;
    end
    chk("full_before_write", {7'h0, d[1]}, 8'h00);
    wr_reg(3'h4, 8'h3c);
    wait_txc();
    rd_reg(3'h2, d);
    chk("busy_pending", {7'h0, d[0]}, 8'h01);
    wait_txc();
    rchk(3'h2, 8'h00, "tx_status_end");
    wait_q();
    chk("tx_first", f[7:0], 8'ha5);
    wait_q();
    chk("tx_second", f[7:0], 8'h3c);
    chk("tx_second_par", {7'h0, f[8]}, {7'h0, pbit(par, 8'h3c)});
    wr_reg(3'h4, 8'h0f);
    repeat (40) @(posedge clock);
    wr_reg(3'h0, 8'h80);
    rchk(3'h2, 8'h00, "tx_status_off");
    wr_reg(3'h4, 8'hf0);
    rchk(3'h2, 8'h00, "tx_status_refused");
    repeat (400) @(posedge clock);
    i_peer.q.delete();
    chk("tx_idle", {7'h0, tx_data_line}, 8'h01);
    par = PAR_NONE;
    arm(8'ha1);
    i_peer.send_frame(8'hc3, 1'b0, 1'b0);
    rchk(3'h3, 8'hc3, "rx_buffer");
    rchk(3'h1, 8'h02, "err_status");
    e_c = e_c + 8'h01;
    irq_chk();
    arm(8'ha0);
    i_peer.send_frame(8'h11, 1'b0, 1'b1);
    i_peer.send_frame(8'h22, 1'b0, 1'b1);
    e_c = e_c + 8'h01;
    e_e = e_e + 8'h01;
    irq_chk();
    // Unread buffer makes a completed frame an overrun, so silence proves the stop
    fork
      i_peer.send_frame(8'h44, 1'b0, 1'b1);
      begin
        repeat (80) @(posedge clock);
        wr_reg(3'h0, 8'h80);
      end
    join
    irq_chk();
    rchk(3'h1, 8'h01, "err_status");
    rchk(3'h3, 8'h11, "rx_buffer");
    i_peer.send_frame(8'h66, 1'b0, 1'b1);
    irq_chk();
    rchk(3'h3, 8'h11, "rx_buffer");
    end_sim();
  end
  initial begin
    repeat (30000) @(posedge clock);
    fails++;
    end_sim();
  end
endmodule : uart_rx_errors_tx_end_bench
`default_nettype wire
